/* File: hw/fsps_consts.vh */
`ifndef FSPS_CONSTS_VH
`define FSPS_CONSTS_VH

// APB register map (byte addresses)
`define FSPS_CTRL_OFS       8'h00

// Control register fields
`define FSPS_IE_BIT         7
`define FSPS_BUSY_BIT       6
`define FSPS_SIG_BIT        5
`define FSPS_REEN_BIT       4
`define FSPS_LOCK_BIT       3
`define FSPS_PW_BIT         2
`define FSPS_PE_BIT         1
`define FSPS_EN_BIT         0
`define FSPS_CTRL_RESET     8'h00

// Command patterns in bits 5:0
`define FSPS_PAT_SIG        6'h21
`define FSPS_PAT_REEN       6'h11
`define FSPS_PAT_LOCK       6'h09
`define FSPS_PAT_WRITE      6'h05
`define FSPS_PAT_ERASE      6'h03
`define FSPS_PAT_LOAD       6'h01

// Arming windows in clock cycles
`define FSPS_STORE_WIN      3'd4
`define FSPS_LOAD_WIN       3'd3

// Pointer layout
`define FSPS_PAGE_LSB       7
`define FSPS_WORD_LSB       1

// Readout addresses
`define FSPS_Z_FUSE_LOW     16'h0000
`define FSPS_Z_LOCK         16'h0001
`define FSPS_Z_FUSE_HIGH    16'h0003
`define FSPS_SIG_LAST       16'h001f
`define FSPS_SIG_RSVD       5'h03
`define FSPS_SIG_ID0        5'h00
`define FSPS_SIG_ID1        5'h02
`define FSPS_SIG_ID2        5'h04

`endif

/* File: hw/fsps_sequencer.v */
// Contract
// R1 - Erase pattern plus store within four cycles erases
// R2 - Erase: halt core only for blocked section
// R3 - Load pattern plus store writes buffer word
// R4 - Buffer cleared after write, re-enable, reset
// R5 - Software writes each buffer slot once
// R6 - Write pattern plus store programs buffered page
// R7 - Write: halt core only for blocked section
// R8 - Interrupt level while enabled and enable bit low
// R9 - Erase/write sets busy, blocks readable section; code sets busy only for readable-section pages
// R10 - Re-enable clears busy before fetching section
// R11 - Lock pattern plus store sets boot locks
// R12 - Zero bits 5:2 program matching locks
// R13 - Software loads pointer 1, sets spare bits
// R14 - Lock programming blocks no section
// R15 - Data memory write refuses commands and readout
// R16 - Software checks data memory flag first
// R17 - Pointer 1 readout returns lock byte
// R18 - Lock readout bits self-clear on use/timeout
// R19 - Pointer 0 low fuse, 3 high fuse
// R20 - Programmed reads zero, unprogrammed reads one
// R21 - Signature readout within three cycles, self-clears
// R22 - Signature row: ids, trims, rest reserved
// R23 - Enable arms store for four cycles
// R24 - Eight-bit control register, resets to zero
// R25 - Only six patterns arm anything
// R26 - Erase/write finish on array done indication
`timescale 1ns/1ps
`include "fsps_consts.vh"

module fsps_sequencer #(
  parameter        PAGE_W    = 9,
  parameter        RWW_PAGES = 288,
  parameter        WORD_W    = 6,
  parameter [7:0]  SIG_ID0   = 8'h5a,  // Arbitrary value
  parameter [7:0]  SIG_ID1   = 8'ha5,  // Arbitrary value
  parameter [7:0]  SIG_ID2   = 8'h3c   // Arbitrary value
) (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire                spm_exec,
  input  wire                lpm_exec,
  input  wire [15:0]         z_ptr,
  input  wire [15:0]         data_register_pair,
  input  wire                data_mem_write_flag,
  input  wire                flash_done,
  input  wire [7:0]          fuse_low_prog,
  input  wire [7:0]          fuse_high_prog,
  input  wire [7:0]          lock_prog_state,
  input  wire [255:0]        cal_row,
  input  wire [WORD_W-1:0]   buf_rd_addr,
  output reg  [15:0]         buf_rd_data,
  output reg                 erase_start,
  output reg                 write_start,
  output reg                 lock_start,
  output reg  [PAGE_W-1:0]   op_page,
  output reg  [3:0]          lock_mask,
  output reg                 core_halt,
  output reg                 rww_read_block,
  output reg                 lpm_hit,
  output reg  [7:0]          lpm_data,
  output reg                 irq
);

  localparam DEPTH = 1 << WORD_W;

  // Operation states
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_ARMED = 2'd1;
  localparam [1:0] ST_FLASH = 2'd2;
  localparam [1:0] ST_LOCK  = 2'd3;

  reg  [1:0]        state_q;
  reg  [7:0]        ctrl_q;
  reg  [2:0]        win_q;
  reg  [15:0]       buf_mem [0:DEPTH-1];
  reg  [DEPTH-1:0]  buf_valid_q;

  wire              wr_acc;
  wire              rd_acc;
  wire              hit_ctrl;
  wire [5:0]        wpat;
  wire [5:0]        cpat;
  wire              pat_ok;
  wire              store_ok;
  wire              load_ok;
  wire              ee_busy;
  wire [PAGE_W-1:0] z_page;
  wire [WORD_W-1:0] z_word;
  wire              page_rww;
  wire              buf_clear;
  wire              load_go;
  reg  [7:0]        sig_byte;
  reg  [7:0]        lock_rd;
  reg               lock_rd_ok;

  assign wr_acc   = psel & penable & pready & pwrite;
  assign rd_acc   = psel & penable & ~pready & ~pwrite;
  assign hit_ctrl = (paddr == `FSPS_CTRL_OFS);
  assign wpat     = pwdata[5:0];
  assign cpat     = ctrl_q[5:0];
  assign ee_busy  = data_mem_write_flag;
  assign z_page   = z_ptr[`FSPS_PAGE_LSB +: PAGE_W];
  assign z_word   = z_ptr[`FSPS_WORD_LSB +: WORD_W];
  assign page_rww = (z_page < RWW_PAGES);

  assign pat_ok = (wpat == `FSPS_PAT_SIG)   | (wpat == `FSPS_PAT_REEN)  | // R25
                  (wpat == `FSPS_PAT_LOCK)  | (wpat == `FSPS_PAT_WRITE) |
                  (wpat == `FSPS_PAT_ERASE) | (wpat == `FSPS_PAT_LOAD);

  // Store accepted while the window is open; signature arming takes none
  assign store_ok = (state_q == ST_ARMED) & spm_exec & (win_q != 3'd0) &
                    (cpat != `FSPS_PAT_SIG) & ~ee_busy;                   // R15 R23
  // Load-program window is the first three cycles of the four
  assign load_ok  = (state_q == ST_ARMED) & lpm_exec & (win_q > 3'd1) &
                    ((cpat == `FSPS_PAT_SIG) | (cpat == `FSPS_PAT_LOCK)) & ~ee_busy; // R15

  assign load_go   = store_ok & (cpat == `FSPS_PAT_LOAD);
  assign buf_clear = (store_ok & (cpat == `FSPS_PAT_REEN)) |
                     ((state_q == ST_FLASH) & flash_done & ctrl_q[`FSPS_PW_BIT]); // R4

  // Signature row: ids from parameters, trims from the array, rest reserved
  always @* begin
    sig_byte = 8'hff;
    if (z_ptr <= `FSPS_SIG_LAST) begin                                     // R22
      case (z_ptr[4:0])
        `FSPS_SIG_ID0:  sig_byte = SIG_ID0;
        `FSPS_SIG_ID1:  sig_byte = SIG_ID1;
        `FSPS_SIG_ID2:  sig_byte = SIG_ID2;
        `FSPS_SIG_RSVD: sig_byte = 8'hff;
        default:        sig_byte = cal_row[{z_ptr[4:0], 3'b000} +: 8];
      endcase
    end
  end

  // Fuse and lock bytes; inputs flag programmed bits, read back inverted
  always @* begin
    lock_rd    = 8'hff;
    lock_rd_ok = 1'b1;
    case (z_ptr)
      `FSPS_Z_FUSE_LOW:  lock_rd = ~fuse_low_prog;                       // R19 R20
      `FSPS_Z_LOCK:      lock_rd = ~lock_prog_state;                     // R17 R20
      `FSPS_Z_FUSE_HIGH: lock_rd = ~fuse_high_prog;                      // R19 R20
      default:           lock_rd_ok = 1'b0;
    endcase
  end

  // APB: one wait state, pready straight from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_ctrl;
      if (rd_acc) begin
        prdata <= hit_ctrl ? {24'h00_0000, ctrl_q} : 32'h0000_0000;
      end
    end
  end

  // Control register and sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= `FSPS_CTRL_RESET;                                    // R24
      state_q     <= ST_IDLE;
      win_q       <= 3'd0;
      erase_start <= 1'b0;
      write_start <= 1'b0;
      lock_start  <= 1'b0;
      op_page     <= {PAGE_W{1'b0}};
      lock_mask   <= 4'h0;
      core_halt   <= 1'b0;
      lpm_hit     <= 1'b0;
      lpm_data    <= 8'h00;
    end else begin
      erase_start <= 1'b0;
      write_start <= 1'b0;
      lock_start  <= 1'b0;
      lpm_hit     <= 1'b0;
      if (wr_acc & hit_ctrl) begin
        ctrl_q[`FSPS_IE_BIT] <= pwdata[`FSPS_IE_BIT];
      end
      case (state_q)
        ST_IDLE: begin
          // Any other combination, or a pending data memory write, is dropped
          if (wr_acc & hit_ctrl & pat_ok & ~ee_busy) begin                // R15 R25
            ctrl_q[5:0] <= wpat;
            win_q       <= `FSPS_STORE_WIN;                               // R23
            state_q     <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          win_q <= win_q - 3'd1;
          if (store_ok) begin
            case (cpat)
              `FSPS_PAT_ERASE, `FSPS_PAT_WRITE: begin
                op_page     <= z_page;                                    // R1 R6
                erase_start <= (cpat == `FSPS_PAT_ERASE);                 // R1
                write_start <= (cpat == `FSPS_PAT_WRITE);                 // R6
                ctrl_q[`FSPS_BUSY_BIT] <= ctrl_q[`FSPS_BUSY_BIT] | page_rww; // R9
                core_halt   <= ~page_rww;                                 // R2 R7
                state_q     <= ST_FLASH;
              end
              `FSPS_PAT_LOCK: begin
                lock_mask  <= ~data_register_pair[5:2];                   // R11 R12
                lock_start <= 1'b1;                                       // R14
                state_q    <= ST_LOCK;
              end
              `FSPS_PAT_REEN: begin
                ctrl_q[`FSPS_BUSY_BIT] <= 1'b0;                           // R10
                ctrl_q[5:0] <= 6'h00;
                state_q     <= ST_IDLE;
              end
              default: begin
                // Page load also frees the readable section
                ctrl_q[`FSPS_BUSY_BIT] <= 1'b0;
                ctrl_q[5:0] <= 6'h00;                                     // R23
                state_q     <= ST_IDLE;
              end
            endcase
          end else if (load_ok & ((cpat == `FSPS_PAT_SIG) | lock_rd_ok)) begin
            lpm_hit     <= 1'b1;
            lpm_data    <= (cpat == `FSPS_PAT_SIG) ? sig_byte : lock_rd;  // R17 R21
            ctrl_q[5:0] <= 6'h00;                                         // R18 R21
            state_q     <= ST_IDLE;
          end else if ((win_q == 3'd1) |
                       ((cpat == `FSPS_PAT_SIG) & (win_q == 3'd2))) begin
            ctrl_q[5:0] <= 6'h00;                                         // R18 R21 R23
            state_q     <= ST_IDLE;
          end
        end
        ST_FLASH: begin
          // Enable bit stays high until the array reports completion
          if (flash_done) begin                                           // R26
            ctrl_q[5:0] <= 6'h00;
            core_halt   <= 1'b0;                                          // R2 R7
            state_q     <= ST_IDLE;
          end
        end
        ST_LOCK: begin
          if (flash_done) begin                                           // R26
            ctrl_q[5:0] <= 6'h00;
            state_q     <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Temporary page buffer; a cleared slot reads as erased
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_slot
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          buf_valid_q[gi] <= 1'b0;                                        // R4
        end else if (buf_clear) begin
          buf_valid_q[gi] <= 1'b0;                                        // R4
        end else if (load_go & (z_word == gi)) begin
          buf_valid_q[gi] <= 1'b1;                                        // R3
        end
      end
    end
  endgenerate

  // Second write to one slot simply overwrites; software must avoid it
  always @(posedge pclk) begin
    if (load_go) begin
      buf_mem[z_word] <= data_register_pair;                              // R3 R5
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_rd_data    <= 16'hffff;
      rww_read_block <= 1'b0;
      irq            <= 1'b0;
    end else begin
      buf_rd_data    <= buf_valid_q[buf_rd_addr] ? buf_mem[buf_rd_addr] : 16'hffff;
      rww_read_block <= ctrl_q[`FSPS_BUSY_BIT];                           // R9 R14
      irq            <= ctrl_q[`FSPS_IE_BIT] & ~ctrl_q[`FSPS_EN_BIT];     // R8
    end
  end

endmodule // fsps_sequencer

/* File: verification/flash_self_program_sequencer_test.sv */
`timescale 1ns/1ps
module flash_self_program_sequencer_test;
  localparam [7:0] ID0 = 8'h66;  // Arbitrary value
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
  logic         data_mem_write_flag = 0;
  logic [7:0]   paddr = 0, fuse_low_prog = 8'h35, fuse_high_prog = 8'h0c, lock_prog_state = 8'h12;
  logic [31:0]  pwdata = 0, rdat;
  logic [5:0]   buf_rd_addr = 0;
  logic [255:0] cal_row;
  int           err_total = 0, n_checks = 0, cyc = 0;
  wire [31:0]   prdata;
  wire [15:0]   z_ptr, data_register_pair, buf_rd_data;
  wire [8:0]    op_page;
  wire [7:0]    lpm_data;
  wire [3:0]    lock_mask;
  wire          pready, pslverr, spm_exec, lpm_exec, flash_done, erase_start, write_start;
  wire          lock_start, core_halt, rww_read_block, lpm_hit, irq;
  fsps_sequencer #(.SIG_ID0(ID0)) dut_u (.*);
  fsps_core_model core_u (.*);
  initial forever #10 pclk = ~pclk;
  task complete_run;
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      complete_run;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat    = prdata;
    slv     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] v);
    apb(1'b1, 8'h00, {24'h0, v});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task tick;
    @(posedge pclk);
    #1;
  endtask
  task rdout(input logic [7:0] pat, input logic [15:0] z, input logic [7:0] e);
    wr(pat);
    core_u.exec(1'b1, z, 16'h0000);
    // The answer pulse stands only one cycle after the accepted edge
    #1;
    chk(lpm_hit, 1'b1);
    chk(lpm_data, e);
    rd(8'h00, 32'h0);
  endtask
  initial begin
    for (int i = 0; i < 32; i++) cal_row[8*i +: 8] = 8'h40 + i;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    chk(slv, 1'b1);
    rdout(8'h09, 16'h0000, ~fuse_low_prog);
    rdout(8'h09, 16'h0001, ~lock_prog_state);
    rdout(8'h09, 16'h0003, ~fuse_high_prog);
    rdout(8'h21, 16'h0000, ID0);
    rdout(8'h21, 16'h0005, 8'h45);
    rdout(8'h21, 16'h0003, 8'hff);
    wr(8'h03);
    repeat (6) @(posedge pclk);
    rd(8'h00, 32'h0);
    wr(8'h87);
    rd(8'h00, 32'h80);
    chk(irq, 1'b1);
    data_mem_write_flag <= 1'b1;
    wr(8'h83);
    core_u.exec(1'b0, 16'h0180, 16'h0);
    rd(8'h00, 32'h80);
    data_mem_write_flag <= 1'b0;
    wr(8'h81);
    core_u.exec(1'b0, 16'h000a, 16'h1234);
    buf_rd_addr <= 6'd5;
    tick;
    tick;
    chk(buf_rd_data, 16'h1234);
    wr(8'h85);
    core_u.exec(1'b0, 16'h0180, 16'h0);
    #1;
    chk(write_start, 1'b1);
    chk(op_page, 9'd3);
    rd(8'h00, 32'hc5);
    chk(irq, 1'b0);
    repeat (25) @(posedge pclk);
    rd(8'h00, 32'hc0);
    chk(buf_rd_data, 16'hffff);
    wr(8'h91);
    core_u.exec(1'b0, 16'h0, 16'h0);
    rd(8'h00, 32'h80);
    chk(rww_read_block, 1'b0);
    core_u.dly <= 5'd2;
    wr(8'h83);
    core_u.exec(1'b0, 16'h9600, 16'h0);
    tick;
    chk(core_halt, 1'b1);
    repeat (6) tick;
    chk(core_halt, 1'b0);
    core_u.dly <= 5'd20;
    wr(8'h89);
    core_u.exec(1'b0, 16'h0001, 16'h00c3);
    #1;
    chk(lock_start, 1'b1);
    chk(lock_mask, 4'hf);
    repeat (25) @(posedge pclk);
    rd(8'h00, 32'h80);
    complete_run;
  end
endmodule // flash_self_program_sequencer_test

/* File: verification/fsps_core_model.sv */
`timescale 1ns/1ps
module fsps_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        erase_start,
  input  wire logic        write_start,
  input  wire logic        lock_start,
  output logic             spm_exec = 1'b0,
  output logic             lpm_exec = 1'b0,
  output logic [15:0]      z_ptr = 16'hffff,
  output logic [15:0]      data_register_pair = 16'hffff,
  output logic             flash_done
);
  logic [4:0] cnt_q;
  logic [4:0] dly = 5'd20;
  // Callers keep one store per slot; one store call runs while the data memory write flag is set
  task automatic exec(input logic ld, input logic [15:0] z, input logic [15:0] d);
    if (ld) lpm_exec <= 1'b1;
    else spm_exec <= 1'b1;
    z_ptr              <= z;
    data_register_pair <= d;
    @(posedge pclk);
    spm_exec           <= 1'b0;
    lpm_exec           <= 1'b0;
    // Operands go stale after the pulse, not held
    z_ptr              <= ~z;
    data_register_pair <= ~d;
  endtask
  // Array timing, delay adjustable for prompt or slow completion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= 5'h00;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt_q == 5'h01);
      if (erase_start || write_start || lock_start) cnt_q <= dly;
      else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule // fsps_core_model

/* File: verification/fsps_seq_monitor.sv */
`timescale 1ns/1ps
module fsps_seq_monitor #(parameter PAGE_W = 9, parameter RWW_PAGES = 288) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              spm_exec,
  input wire logic              lpm_exec,
  input wire logic [15:0]       z_ptr,
  input wire logic [15:0]       data_register_pair,
  input wire logic              data_mem_write_flag,
  input wire logic              flash_done,
  input wire logic              erase_start,
  input wire logic              write_start,
  input wire logic              lock_start,
  input wire logic [PAGE_W-1:0] op_page,
  input wire logic [3:0]        lock_mask,
  input wire logic              core_halt,
  input wire logic              rww_read_block,
  input wire logic              lpm_hit,
  input wire logic              irq
);
  wire       st    = erase_start || write_start;
  wire       readable_during_write_section   = op_page < RWW_PAGES;
  wire [8:0] zpage = z_ptr[15:7];
  wire [3:0] dbits = data_register_pair[5:2];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_ans; psel && penable && pready; endsequence
  AST_APB_ONE_WAIT: assert property ($rose(penable) && psel |-> s_wait ##1 s_ans)
    else $error("apb wait state wrong");
  AST_PAGE_LATCH: assert property (st |-> op_page == $past(zpage))
    else $error("page not latched");
  AST_BLOCKED_DURING_WRITE_SECTION_HALT: assert property (st && !readable_during_write_section |-> core_halt)
    else $error("core not halted");
  AST_RWW_NO_HALT: assert property (st && readable_during_write_section |-> !core_halt)
    else $error("core halted for readable section");
  AST_BUSY_BLOCK: assert property (st && readable_during_write_section |=> rww_read_block)
    else $error("section not blocked");
  AST_HALT_DONE: assert property (core_halt && flash_done |=> !core_halt)
    else $error("halt kept after done");
  AST_LOCK_MASK: assert property (lock_start |-> lock_mask == ~$past(dbits))
    else $error("lock mask wrong");
  AST_LOCK_FREE: assert property (lock_start |-> !core_halt)
    else $error("lock programming halts core");
  AST_DM_REFUSE: assert property (data_mem_write_flag && (spm_exec || lpm_exec)
    |=> !(st || lock_start || lpm_hit)) else $error("command taken during data write");
  AST_IRQ_ARMED: assert property (st |-> !irq)
    else $error("irq while enable high");
endmodule // fsps_seq_monitor

bind fsps_sequencer fsps_seq_monitor #(.PAGE_W(PAGE_W), .RWW_PAGES(RWW_PAGES)) mon_u (.*);
